//--- logic/tce_event_gen.sv
// count tick and trigger source: prescaler or event pin edges, trigger pin or software
// assumes pins already synchronous to the clock

`timescale 1ns/10ps

module tce_event_gen (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic event_pin_in,
  input wire logic trig_pin_in,
  tce_link_if.gen link
);

  typedef struct packed {
    logic [tce_pkg::PRESC_W-1:0] presc;
    logic ev_prev;
    logic trg_prev;
    logic tick;
    logic trig;
  } tce_gen_state_t;

  tce_gen_state_t s;
  tce_gen_state_t next_s;
  logic [tce_pkg::PRESC_W-1:0] presc_mask;

  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
    edge_hit = ((sel & tce_pkg::EDGE_RISE) != 2'h0 && now && !prev) ||
      ((sel & tce_pkg::EDGE_FALL) != 2'h0 && !now && prev);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // divide by two to the power of the select field
    presc_mask = ~(7'h7f << link.presc_sel);
    next_s.presc = link.run ? s.presc + 7'h01 : 7'h00;
    next_s.ev_prev = event_pin_in;
    next_s.trg_prev = trig_pin_in;
    if (link.evsel) begin
      next_s.tick = link.run && edge_hit(link.ev_edge, event_pin_in, s.ev_prev);
    end else begin
      next_s.tick = link.run && ((s.presc & presc_mask) == presc_mask);
    end
    // software trigger counts exactly like a pin edge
    next_s.trig = link.sw_trig || edge_hit(link.trg_edge, trig_pin_in, s.trg_prev);
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.tick = s.tick;
  assign link.trig = s.trig;

endmodule

//--- logic/tce_flags.sv
// sticky event flags, mask and the level interrupt
// assumes event pulses last one cycle

`timescale 1ns/10ps

module tce_flags (
  input wire logic mclk_in,
  input wire logic rst_in,
  tce_link_if.flags link
);

  typedef struct packed {
    logic [tce_pkg::ST_W-1:0] status;
    logic [tce_pkg::ST_W-1:0] mask;
    logic irq;
  } tce_flag_state_t;

  tce_flag_state_t s;
  tce_flag_state_t next_s;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // set wins over a write-one clear in the same cycle
    next_s.status = (s.status & ~link.clr_wr) | link.evt;
    next_s.mask = link.mask_wr ? link.mask_data : s.mask;
    next_s.irq = |(next_s.status & ~next_s.mask);
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s.status <= tce_pkg::STATUS_RESET;
      s.mask <= tce_pkg::MASK_RESET;
      s.irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign link.status = s.status;
  assign link.mask = s.mask;
  assign link.irq = s.irq;

endmodule

//--- logic/tce_timer.sv
// 16-bit timer instance: apb registers, counter, compare channels and pin outputs
// assumes a synchronous active-high reset and inputs synchronous to mclk_in
//
// Design decision made here: register access over APB.

`timescale 1ns/10ps

module tce_timer #(
  parameter int INSTANCE = 0
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic event_input_pin_in,
  input wire logic ext_trigger_pin_in,
  input wire logic companion_sync_in,
  output logic timer_output_0_out,
  output logic timer_output_1_out,
  output logic adc_trigger_out,
  output logic irq_out
);

  localparam logic [31:0] CTL1_IDX = (INSTANCE == 1) ? tce_pkg::CTL1_IDX_T1 :
    (INSTANCE == 2) ? tce_pkg::CTL1_IDX_T2 :
    (INSTANCE == 3) ? tce_pkg::CTL1_IDX_T3 : tce_pkg::CTL1_IDX_T0;
  localparam logic [31:0] CTL1_ADDR = {CTL1_IDX[29:0], 2'b00};

  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [3:0] edge_sel;
    logic [tce_pkg::CNT_W-1:0] cmp0;
    logic [tce_pkg::CNT_W-1:0] cmp1;
    logic [tce_pkg::CNT_W-1:0] buf0;
    logic [tce_pkg::CNT_W-1:0] buf1;
    logic [tce_pkg::CNT_W-1:0] cnt;
    tce_pkg::tce_cnt_state_t st;
    logic out0;
    logic out1;
    logic adc_trig;
    logic sw_trig;
    logic [tce_pkg::ST_W-1:0] evt;
    logic [31:0] rdata;
  } tce_core_state_t;

  tce_core_state_t s;
  tce_core_state_t next_s;

  tce_link_if link ();

  logic setup;
  logic wr;
  logic hit_ctl0;
  logic hit_ctl1;
  logic hit_cmp0;
  logic hit_cmp1;
  logic hit_count;
  logic hit_status;
  logic hit_mask;
  logic hit_edge;
  logic mapped;
  logic [31:0] rd_mux;
  logic [2:0] mode;
  logic tuning;
  logic run;
  logic pulse_mode;
  logic wrap;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  tce_event_gen u_gen (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .event_pin_in(event_input_pin_in),
    .trig_pin_in(ext_trigger_pin_in),
    .link(link.gen)
  );

  tce_flags u_flags (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .link(link.flags)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup = psel_in && !penable_in;
  assign wr = psel_in && penable_in && pwrite_in;
  assign hit_ctl0 = (paddr_in == tce_pkg::CTL0_ADDR);
  assign hit_ctl1 = (paddr_in == CTL1_ADDR);
  assign hit_cmp0 = (paddr_in == tce_pkg::CMP0_ADDR);
  assign hit_cmp1 = (paddr_in == tce_pkg::CMP1_ADDR);
  assign hit_count = (paddr_in == tce_pkg::COUNT_ADDR);
  assign hit_status = (paddr_in == tce_pkg::STATUS_ADDR);
  assign hit_mask = (paddr_in == tce_pkg::MASK_ADDR);
  assign hit_edge = (paddr_in == tce_pkg::EDGE_ADDR);
  assign mapped = hit_ctl0 || hit_ctl1 || hit_cmp0 || hit_cmp1 || hit_count ||
    hit_status || hit_mask || hit_edge;

  // zero wait states: every access phase completes at once
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctl0) begin
      rd_mux = {24'h00_0000, s.ctl0};
    end
    if (hit_ctl1) begin
      // trigger bit and reserved bits are never stored
      rd_mux = {24'h00_0000, s.ctl1};
    end
    if (hit_cmp0) begin
      rd_mux = {16'h0000, s.cmp0};
    end
    if (hit_cmp1) begin
      rd_mux = {16'h0000, s.cmp1};
    end
    if (hit_count) begin
      rd_mux = {16'h0000, s.cnt};
    end
    if (hit_status) begin
      rd_mux = {29'h0000_0000, link.status};
    end
    if (hit_mask) begin
      rd_mux = {29'h0000_0000, link.mask};
    end
    if (hit_edge) begin
      rd_mux = {28'h000_0000, s.edge_sel};
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  assign mode = s.ctl1[tce_pkg::CTL1_MODE_LSB +: tce_pkg::MODE_W];
  assign tuning = s.ctl1[tce_pkg::CTL1_TUNE_BIT] && (INSTANCE == tce_pkg::TUNING_INSTANCE);
  assign run = s.ctl0[tce_pkg::CTL0_RUN_BIT];
  assign pulse_mode = (mode == tce_pkg::MODE_EXT_TRIG) || (mode == tce_pkg::MODE_ONE_SHOT);
  // free running wraps at the top, every other mode at compare 0
  assign wrap = (mode == tce_pkg::MODE_FREE_RUN) ? (s.cnt == tce_pkg::CNT_TOP) :
    (s.cnt == s.buf0);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sw_trig = 1'b0;
    next_s.adc_trig = 1'b0;
    next_s.evt = 3'h0;
    if (setup) begin
      next_s.rdata = rd_mux;
    end

    if (wr) begin
      if (hit_ctl0 && pstrb_in[0]) begin
        next_s.ctl0 = pwdata_in[7:0] & tce_pkg::CTL0_WMASK;
      end
      if (hit_ctl1 && pstrb_in[0]) begin
        next_s.ctl1 = pwdata_in[7:0] & tce_pkg::CTL1_KEEP;
        next_s.sw_trig = pwdata_in[tce_pkg::CTL1_SWTRIG_BIT];
      end
      if (hit_edge && pstrb_in[0]) begin
        next_s.edge_sel = pwdata_in[3:0];
      end
      for (int b = 0; b < 2; b++) begin
        if (hit_cmp0 && pstrb_in[b]) begin
          next_s.cmp0[b*8 +: 8] = pwdata_in[b*8 +: 8];
        end
        if (hit_cmp1 && pstrb_in[b]) begin
          next_s.cmp1[b*8 +: 8] = pwdata_in[b*8 +: 8];
        end
      end
    end

    unique case (s.st)
      tce_pkg::CS_IDLE: begin
        next_s.cnt = tce_pkg::CNT_RESET;
        next_s.buf0 = s.cmp0;
        next_s.buf1 = s.cmp1;
        next_s.out0 = 1'b0;
        next_s.out1 = 1'b0;
        if (run) begin
          next_s.st = pulse_mode ? tce_pkg::CS_WAIT_TRIG : tce_pkg::CS_COUNT;
        end
      end
      tce_pkg::CS_WAIT_TRIG: begin
        // one-shot and pwm start on a pin edge or the software trigger
        if (link.trig) begin
          next_s.st = tce_pkg::CS_COUNT;
          next_s.cnt = tce_pkg::CNT_RESET;
          next_s.buf0 = s.cmp0;
          next_s.buf1 = s.cmp1;
        end
      end
      tce_pkg::CS_COUNT: begin
        if (tuning && companion_sync_in) begin
          next_s.cnt = tce_pkg::CNT_RESET;
        end else if (mode == tce_pkg::MODE_EXT_TRIG && link.trig) begin
          // retrigger restarts the period
          next_s.cnt = tce_pkg::CNT_RESET;
          next_s.out1 = 1'b0;
        end else if (link.tick) begin
          if (s.cnt == s.buf1) begin
            next_s.evt[tce_pkg::ST_CC1] = 1'b1;
            // equal compares toggle once per period, giving half duty
            next_s.out1 = pulse_mode ? 1'b1 : !s.out1;
          end
          if (wrap) begin
            next_s.cnt = tce_pkg::CNT_RESET;
            next_s.buf0 = s.cmp0;
            next_s.buf1 = s.cmp1;
            if (mode == tce_pkg::MODE_FREE_RUN) begin
              next_s.evt[tce_pkg::ST_OVF] = 1'b1;
            end else begin
              // compare 0 at all ones wraps with no overflow flag
              next_s.evt[tce_pkg::ST_CC0] = 1'b1;
              next_s.out0 = !s.out0;
            end
            if (pulse_mode) begin
              next_s.out1 = 1'b0;
            end
            if (mode == tce_pkg::MODE_ONE_SHOT) begin
              next_s.st = tce_pkg::CS_WAIT_TRIG;
            end
          end else begin
            next_s.cnt = s.cnt + 16'h0001;
          end
        end
      end
      default: begin
        next_s.st = tce_pkg::CS_IDLE;
      end
    endcase

    if (!run) begin
      next_s.st = tce_pkg::CS_IDLE;
    end
    // tuning turns compare matches into converter start pulses only
    if (tuning) begin
      next_s.adc_trig = next_s.evt[tce_pkg::ST_CC0] || next_s.evt[tce_pkg::ST_CC1];
      next_s.evt = 3'h0;
      next_s.out0 = 1'b0;
      next_s.out1 = 1'b0;
    end
    // pins stay low while counting events
    if (mode == tce_pkg::MODE_EVENT) begin
      next_s.out0 = 1'b0;
      next_s.out1 = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s.ctl0 <= tce_pkg::CTL0_RESET;
      s.ctl1 <= tce_pkg::CTL1_RESET;
      s.edge_sel <= tce_pkg::EDGE_RESET;
      s.cmp0 <= tce_pkg::CMP_RESET;
      s.cmp1 <= tce_pkg::CMP_RESET;
      s.buf0 <= tce_pkg::CMP_RESET;
      s.buf1 <= tce_pkg::CMP_RESET;
      s.cnt <= tce_pkg::CNT_RESET;
      s.st <= tce_pkg::CS_IDLE;
      s.out0 <= 1'b0;
      s.out1 <= 1'b0;
      s.adc_trig <= 1'b0;
      s.sw_trig <= 1'b0;
      s.evt <= 3'h0;
      s.rdata <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // link and outputs
  // ----------------------------------------------------------------
  assign link.run = run && (s.st != tce_pkg::CS_IDLE);
  assign link.presc_sel = s.ctl0[tce_pkg::CTL0_PRESC_LSB +: tce_pkg::PRESC_SEL_W];
  // event count mode always counts pin edges
  assign link.evsel = s.ctl1[tce_pkg::CTL1_EVSEL_BIT] || (mode == tce_pkg::MODE_EVENT);
  assign link.ev_edge = s.edge_sel[tce_pkg::EV_EDGE_LSB +: tce_pkg::EDGE_W];
  assign link.trg_edge = s.edge_sel[tce_pkg::TRG_EDGE_LSB +: tce_pkg::EDGE_W];
  assign link.sw_trig = s.sw_trig;
  assign link.evt = s.evt;
  assign link.clr_wr = (wr && hit_status && pstrb_in[0]) ? pwdata_in[2:0] : 3'h0;
  assign link.mask_wr = wr && hit_mask && pstrb_in[0];
  assign link.mask_data = pwdata_in[2:0];

  assign prdata_out = s.rdata;
  assign timer_output_0_out = s.out0;
  assign timer_output_1_out = s.out1;
  assign adc_trigger_out = s.adc_trig;
  assign irq_out = link.irq;

endmodule

//--- shared/tce_link_if.sv
// signals between the timer core, its event generator and its flag block
// assumes all three run on the one peripheral clock

`timescale 1ns/10ps

interface tce_link_if;
  logic run;
  logic [2:0] presc_sel;
  logic evsel;
  logic [1:0] ev_edge;
  logic [1:0] trg_edge;
  logic sw_trig;
  logic tick;
  logic trig;
  logic [2:0] evt;
  logic [2:0] clr_wr;
  logic mask_wr;
  logic [2:0] mask_data;
  logic [2:0] status;
  logic [2:0] mask;
  logic irq;

  modport core (output run, presc_sel, evsel, ev_edge, trg_edge, sw_trig, evt, clr_wr,
    mask_wr, mask_data, input tick, trig, status, mask, irq);
  modport gen (input run, presc_sel, evsel, ev_edge, trg_edge, sw_trig, output tick, trig);
  modport flags (input evt, clr_wr, mask_wr, mask_data, output status, mask, irq);
endinterface

//--- shared/tce_pkg.sv
// constants, field layouts and types of the timer unit with control register 1
// assumes a 32-bit apb slave and one 200 mhz clock for everything

package tce_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int PRESC_W = 7;
  localparam int ST_W = 3;

  // ----------------------------------------------------------------
  // register indices of control register 1, one per timer instance
  // ----------------------------------------------------------------
  localparam logic [31:0] CTL1_IDX_T0 = 32'h0fff_f661;
  localparam logic [31:0] CTL1_IDX_T1 = 32'h0fff_f661;
  localparam logic [31:0] CTL1_IDX_T2 = 32'h0fff_f681;
  localparam logic [31:0] CTL1_IDX_T3 = 32'h0fff_f6a1;

  // ----------------------------------------------------------------
  // byte addresses of the remaining registers
  // ----------------------------------------------------------------
  localparam logic [31:0] CTL0_ADDR = 32'h0000_0000;
  localparam logic [31:0] CMP0_ADDR = 32'h0000_0004;
  localparam logic [31:0] CMP1_ADDR = 32'h0000_0008;
  localparam logic [31:0] COUNT_ADDR = 32'h0000_000c;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0010;
  localparam logic [31:0] MASK_ADDR = 32'h0000_0014;
  localparam logic [31:0] EDGE_ADDR = 32'h0000_0018;

  // ----------------------------------------------------------------
  // control register 0
  // ----------------------------------------------------------------
  localparam int CTL0_RUN_BIT = 7;
  localparam int CTL0_PRESC_LSB = 0;
  localparam int PRESC_SEL_W = 3;
  localparam logic [7:0] CTL0_RESET = 8'h00;
  localparam logic [7:0] CTL0_WMASK = 8'h87;

  // ----------------------------------------------------------------
  // control register 1
  // ----------------------------------------------------------------
  localparam int CTL1_TUNE_BIT = 7;
  localparam int CTL1_SWTRIG_BIT = 6;
  localparam int CTL1_EVSEL_BIT = 5;
  localparam int CTL1_MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam logic [7:0] CTL1_RESET = 8'h00;
  localparam logic [7:0] CTL1_KEEP = 8'ha7;
  localparam int TUNING_INSTANCE = 1;

  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_EVENT = 3'h1;
  localparam logic [2:0] MODE_EXT_TRIG = 3'h2;
  localparam logic [2:0] MODE_ONE_SHOT = 3'h3;
  localparam logic [2:0] MODE_FREE_RUN = 3'h5;

  // ----------------------------------------------------------------
  // edge select register, status and mask
  // ----------------------------------------------------------------
  localparam int EV_EDGE_LSB = 0;
  localparam int TRG_EDGE_LSB = 2;
  localparam int EDGE_W = 2;
  localparam logic [3:0] EDGE_RESET = 4'h0;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  localparam int ST_CC0 = 0;
  localparam int ST_CC1 = 1;
  localparam int ST_OVF = 2;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h7;

  localparam logic [15:0] CMP_RESET = 16'hffff;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_TOP = 16'hffff;

  typedef enum logic [1:0] {CS_IDLE, CS_WAIT_TRIG, CS_COUNT} tce_cnt_state_t;

endpackage

//--- verification/tce_pins_model.sv
// stand-in for the pins beyond the timer: event input pulses, idle trigger input
// assumes one-cycle requests spaced at least four cycles apart
`timescale 1ns/10ps
module tce_pins_model (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic pulse_req_in,
  output logic event_input_pin_out,
  output logic ext_trigger_pin_out
);
  logic [1:0] phase;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      phase <= 2'h0;
    end else if (phase != 2'h0 || pulse_req_in) begin
      phase <= phase + 2'h1;
    end
  end
  // two cycles high, two low: exactly one rising edge per request
  assign event_input_pin_out = (phase == 2'h1) || (phase == 2'h2);
  // trigger pin left low so only software can start a pulse
  assign ext_trigger_pin_out = 1'b0;
endmodule

//--- verification/tce_timer_checker.sv
// assertions on the timer's bus answers, read-back and pin outputs
// assumes it is bound to tce_timer and sees one clock with synchronous reset
`timescale 1ns/10ps
module tce_timer_checker #(
  parameter int INSTANCE = 0
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic timer_output_0_out,
  input wire logic timer_output_1_out,
  input wire logic adc_trigger_out,
  input wire logic irq_out
);
  // ----------------------------------------------------------------
  // helper: mode field as last written
  // ----------------------------------------------------------------
  localparam logic [31:0] IDX = (INSTANCE == 2) ? tce_pkg::CTL1_IDX_T2 :
    (INSTANCE == 3) ? tce_pkg::CTL1_IDX_T3 : tce_pkg::CTL1_IDX_T0;
  localparam logic [31:0] CTL1_A = IDX << 2;
  logic [2:0] mode_q;
  logic wr_ok;
  assign wr_ok = psel_in && penable_in && pwrite_in && pready_out;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mode_q <= 3'h0;
    end else if (wr_ok && paddr_in == CTL1_A && pstrb_in[0]) begin
      mode_q <= pwdata_in[2:0];
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_ready; psel_in && penable_in |-> pready_out; endproperty
  a_ready: assert property (p_ready) else $error("access phase without ready");
  property p_err_idle; !(psel_in && penable_in) |-> !pslverr_out; endproperty
  a_err_idle: assert property (p_err_idle) else $error("error outside access");
  property p_err_ctl1; psel_in && penable_in && paddr_in == CTL1_A |-> !pslverr_out; endproperty
  a_err_ctl1: assert property (p_err_ctl1) else $error("control 1 refused");
  property p_err_hole; psel_in && penable_in && paddr_in == 32'h0000_0100 |-> pslverr_out;
  endproperty
  a_err_hole: assert property (p_err_hole) else $error("unmapped access accepted");
  property p_rd_zero;
    psel_in && !penable_in && !pwrite_in && paddr_in == CTL1_A
      |=> prdata_out[6] == 1'b0 && prdata_out[4:3] == 2'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("trigger or reserved bit set");
  property p_hold; !(psel_in && !penable_in) |=> $stable(prdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // interrupt may lag a cycle behind the mask write
  property p_mask_all;
    wr_ok && paddr_in == tce_pkg::MASK_ADDR && pstrb_in[0] && pwdata_in[2:0] == 3'h7
      |=> ##1 !irq_out;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("masked interrupt still high");
  property p_event_quiet;
    (mode_q == tce_pkg::MODE_EVENT) [*3] |-> !timer_output_0_out && !timer_output_1_out;
  endproperty
  a_event_quiet: assert property (p_event_quiet) else $error("output in event mode");
  property p_adc_off; INSTANCE != tce_pkg::TUNING_INSTANCE |-> !adc_trigger_out; endproperty
  a_adc_off: assert property (p_adc_off) else $error("trigger outside tuning");
  c_irq: cover property ($rose(irq_out));
  c_out1: cover property ($changed(timer_output_1_out));
  c_err: cover property (pslverr_out);
endmodule

//--- verification/tce_timer_tb.sv
// self-checking bench: registers, software trigger, event count and interval modes
// assumes package, interface, design, pin model and checker compiled first
`timescale 1ns/10ps
module tce_timer_tb;
  localparam logic [31:0] CTL1_A = {tce_pkg::CTL1_IDX_T0[29:0], 2'b00};
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ev_req = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, ev_pin, trg_pin, out0, out1, adc, irq;
  int num_errors = 0;
  int checked = 0;
  always #2.5 mclk_in = ~mclk_in;
  tce_timer #(.INSTANCE(0)) uut (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .event_input_pin_in(ev_pin), .ext_trigger_pin_in(trg_pin), .companion_sync_in(1'b0),
    .timer_output_0_out(out0), .timer_output_1_out(out1), .adc_trigger_out(adc),
    .irq_out(irq));
  tce_pins_model u_pins (.mclk_in(mclk_in), .rst_in(rst_in), .pulse_req_in(ev_req),
    .event_input_pin_out(ev_pin), .ext_trigger_pin_out(trg_pin));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic fail_wait();
    num_errors++;
    $display("mismatch at %0t: wait %h expected %h", $time, 1'b0, 1'b1);
    print_verdict();
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic err);
    int n;
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_wait();
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    bus(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    bus(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp);
  endtask
  task automatic wait_out1(input logic lvl, output int n);
    n = 0;
    while (out1 !== lvl && n < 64) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 64) fail_wait();
  endtask
  task automatic events(input int k);
    repeat (k) begin
      @(posedge mclk_in);
      ev_req <= 1'b1;
      @(posedge mclk_in);
      ev_req <= 1'b0;
      repeat (4) @(posedge mclk_in);
    end
    repeat (4) @(posedge mclk_in);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    logic [31:0] r;
    logic e;
    rd(CTL1_A, 32'h0000_0000);
    rd(tce_pkg::MASK_ADDR, 32'h0000_0007);
    rd(tce_pkg::CMP0_ADDR, 32'h0000_ffff);
    bus(1'b0, 32'h0000_0100, 32'h0000_0000, r, e);
    check({31'h0, e}, 32'h0000_0001);
    // bit 7 left clear here: tuning belongs to instance 1 only
    wr(CTL1_A, 32'h0000_007d);
    rd(CTL1_A, 32'h0000_0025);
    wr(CTL1_A, 32'h0000_0000);
    $display("test reset and control register done");
  endtask
  task automatic test_swtrig();
    int n;
    wr(tce_pkg::CMP0_ADDR, 32'h0000_000a);
    wr(tce_pkg::CMP1_ADDR, 32'h0000_0004);
    wr(CTL1_A, 32'h0000_0003);
    wr(tce_pkg::CTL0_ADDR, 32'h0000_0080);
    repeat (16) @(posedge mclk_in);
    check({31'h0, out1}, 32'h0000_0000);
    wr(CTL1_A, 32'h0000_0043);
    wait_out1(1'b1, n);
    wait_out1(1'b0, n);
    repeat (30) @(posedge mclk_in);
    check({31'h0, out1}, 32'h0000_0000);
    rd(CTL1_A, 32'h0000_0003);
    wr(tce_pkg::CTL0_ADDR, 32'h0000_0000);
    $display("test software trigger done");
  endtask
  task automatic test_event();
    wr(tce_pkg::EDGE_ADDR, 32'h0000_0001);
    wr(tce_pkg::CMP0_ADDR, 32'h0000_0005);
    wr(tce_pkg::CMP1_ADDR, 32'h0000_ffff);
    wr(tce_pkg::STATUS_ADDR, 32'h0000_0007);
    wr(CTL1_A, 32'h0000_0021);
    wr(tce_pkg::CTL0_ADDR, 32'h0000_0080);
    events(3);
    rd(tce_pkg::COUNT_ADDR, 32'h0000_0003);
    repeat (20) @(posedge mclk_in);
    rd(tce_pkg::COUNT_ADDR, 32'h0000_0003);
    check({30'h0, out1, out0}, 32'h0000_0000);
    events(3);
    rd(tce_pkg::COUNT_ADDR, 32'h0000_0000);
    rd(tce_pkg::STATUS_ADDR, 32'h0000_0001);
    wr(tce_pkg::CTL0_ADDR, 32'h0000_0000);
    wr(CTL1_A, 32'h0000_0000);
    wr(tce_pkg::EDGE_ADDR, 32'h0000_0000);
    wr(tce_pkg::STATUS_ADDR, 32'h0000_0007);
    $display("test event count done");
  endtask
  task automatic test_interval();
    int n;
    wr(tce_pkg::CMP0_ADDR, 32'h0000_0003);
    wr(tce_pkg::CMP1_ADDR, 32'h0000_0003);
    wr(tce_pkg::MASK_ADDR, 32'h0000_0005);
    wr(tce_pkg::CTL0_ADDR, 32'h0000_0080);
    wait_out1(~out1, n);
    wait_out1(~out1, n);
    check(32'(n), 32'h0000_0004);
    wait_out1(~out1, n);
    check(32'(n), 32'h0000_0004);
    rd(tce_pkg::STATUS_ADDR, 32'h0000_0003);
    check({31'h0, irq}, 32'h0000_0001);
    wr(tce_pkg::CMP1_ADDR, 32'h0000_ffff);
    wr(tce_pkg::MASK_ADDR, 32'h0000_0007);
    wr(tce_pkg::CTL0_ADDR, 32'h0000_0000);
    wr(tce_pkg::STATUS_ADDR, 32'h0000_0007);
    rd(tce_pkg::STATUS_ADDR, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    $display("test interval done");
  endtask
  task automatic test_overflow();
    logic [31:0] a, b;
    logic e;
    wr(CTL1_A, 32'h0000_0005);
    wr(tce_pkg::CTL0_ADDR, 32'h0000_0080);
    repeat (4) @(posedge mclk_in);
    bus(1'b0, tce_pkg::COUNT_ADDR, 32'h0000_0000, a, e);
    repeat (65540) @(posedge mclk_in);
    bus(1'b0, tce_pkg::COUNT_ADDR, 32'h0000_0000, b, e);
    rd(tce_pkg::STATUS_ADDR, 32'h0000_0006);
    check(32'h0001_0000 + b - a, 32'h0001_0007);
    $display("test overflow done");
  endtask
  initial begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    test_reset();
    test_swtrig();
    test_event();
    test_interval();
    test_overflow();
    print_verdict();
  end
endmodule
bind tce_timer tce_timer_checker #(.INSTANCE(INSTANCE)) u_chk (.mclk_in(mclk_in),
  .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .timer_output_0_out(timer_output_0_out), .timer_output_1_out(timer_output_1_out),
  .adc_trigger_out(adc_trigger_out), .irq_out(irq_out));
